//--- common/rph_defines.vh
// Constants shared by the radio packet handler design.
`ifndef RPH_DEFINES_VH
`define RPH_DEFINES_VH
`define RPH_CCITT_POLY 16'h1021
`define RPH_CCITT_SEED 16'h1D0F
`define RPH_IBM_POLY 16'h8005
`define RPH_IBM_SEED 16'hFFFF
`define RPH_DCF_MANCH 2'h1
`define RPH_DCF_WHITE 2'h2
`define RPH_WHITE_SEED 9'h1FF
`define RPH_FIXED_LEN_MAX 11'h7FF
`define RPH_VAR_LEN_MAX 8'hFF
`define RPH_CRC_BITS 4'hF
`define RPH_FIFO_DEPTH 8
`define RPH_FIFO_AW 3
`define RPH_BYTE_LAST 3'h7
`endif

//--- logic/rph_packet_handler.v
// Radio packet handler: continuous-mode pin paths, packet framer and deframer, payload FIFO.
// Operation
// - Continuous transmit: drive data clock out, sample data pin on its rising edge.
// - Continuous receive without bit sync: raw demodulator bit on data pin, no clock.
// - Continuous receive with bit sync: clean data plus clock, data changes on falling edge.
// - Bit synchroniser is always in use in packet mode.
// - Packet mode moves data through the FIFO; host may use it in sleep or standby.
// - Format 0 with nonzero length selects fixed framing, 1 to 2047 bytes.
// - Format 1 selects variable framing; first byte gives length up to 255.
// - Format 0 with length 0 is unlimited; length setting does not count bytes.
// - Unlimited receive without sync: no address, Manchester or dewhitening; fill bit starts filling.
// - Unlimited mode appends CRC on transmit, never checks it nor raises receive flags.
// - Transmit prepends preamble and sync, optionally appends CRC and applies DC-free coding.
// - Before start condition send preamble, or constant zero when preamble count is zero.
// - Start select 1: start the packet once one byte is in the FIFO.
// - Start select 0: start once FIFO level exceeds the threshold by one.
// - A start condition met before transmit begins lets the packet start as soon as the preamble has been sent.
// - Receive strips preamble and sync, decodes, filters; only payload reaches the FIFO.
// - Fixed receive takes exactly the programmed length after sync.
// - Variable receive loads length from first byte; over maximum discards the packet.
// - Address check compares first (fixed) or second (variable) byte; mismatch stops reception.
// - CRC enable checks the received CRC and reports it on the good flag.
// - Payload complete goes out on digital output 0; FIFO stays readable afterwards.
// - CRC failure clears FIFO and hides completion unless the keep bit is set.
// - CRC is CCITT with seed 1D0F complemented, or IBM with seed FFFF.
// - Manchester codes payload and CRC as 1 to 10 and 0 to 01.
// - Whitening XORs payload and CRC with a 9-bit LFSR sequence both ways.
`timescale 1ns/10ps
`include "rph_defines.vh"

module rph_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `RPH_FIFO_DEPTH,
  parameter AW = `RPH_FIFO_AW
) (
  input wire clk, // System clock.
  input wire rst_n, // Synchronised reset, active low.
  input wire flush, // Empties the FIFO.
  input wire in_valid, // Write request.
  output wire in_ready, // Room for a word.
  input wire [WIDTH-1:0] in_data, // Word written.
  output wire out_valid, // A word is held.
  input wire out_ready, // Read request.
  output wire [WIDTH-1:0] out_data, // Oldest word.
  output wire [7:0] level // Words held.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rp_reg];
  assign level = {{(7-AW){1'b0}}, cnt_reg};
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;

  always @(posedge clk)
  begin
    if (push)
      mem[wp_reg] <= in_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      if (pop)
        rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

module rph_packet_handler #(
  parameter FIFO_DEPTH = `RPH_FIFO_DEPTH,
  parameter FIFO_AW = `RPH_FIFO_AW
) (
  input wire clk_sys, // System clock, 50 MHz.
  input wire rstn, // Asynchronous reset, active low.
  input wire packet_mode, // 1 packet mode, 0 continuous mode.
  input wire mode_tx, // Transmit mode.
  input wire mode_rx, // Receive mode.
  input wire bit_sync_enable, // Bit synchroniser on in continuous mode.
  input wire frame_format_select, // 0 fixed or unlimited, 1 variable.
  input wire [10:0] payload_length_setting, // Payload length or receive maximum.
  input wire transmit_start_select, // 1 start on first byte, 0 on threshold.
  input wire [5:0] fifo_threshold_setting, // FIFO threshold.
  input wire sync_detect_enable, // Sync word detection on.
  input wire fifo_fill_select, // Fill FIFO without sync when sync is off, unlimited format only.
  input wire [15:0] preamble_bytes, // Preamble length in bytes.
  input wire [2:0] sync_bytes, // Sync word length, 1 to 4 bytes.
  input wire [31:0] sync_word, // Sync word, first byte in the top bits.
  input wire crc_enable_bit, // CRC append and check.
  input wire crc_fail_keep_bit, // Keep payload on CRC failure.
  input wire crc_variant_select, // 0 CCITT, 1 IBM.
  input wire [1:0] dc_balance_select, // 01 Manchester, 10 whitening.
  input wire addr_check_enable, // Node address filtering.
  input wire [7:0] local_node_id, // Node address.
  input wire host_wr_valid, // Host writes a FIFO byte.
  input wire [7:0] host_wr_data, // Byte from host.
  output wire host_wr_ready, // FIFO has room.
  output wire host_rd_valid, // FIFO holds a byte.
  input wire host_rd_ready, // Host reads a FIFO byte.
  output wire [7:0] host_rd_data, // Byte to host.
  output wire [7:0] fifo_level, // FIFO fill level.
  input wire bit_clk_in, // Modem bit clock.
  input wire rx_bit_in, // Raw demodulator bit.
  output reg tx_bit_out, // Bit to modulator.
  output reg digital_output_0, // Payload complete or packet done.
  output reg digital_output_1, // Data clock.
  input wire digital_output_2_in, // Data pin level.
  output reg digital_output_2_out, // Data pin drive value.
  output reg digital_output_2_oe, // Data pin drive enable.
  output reg crc_good_flag, // Received CRC matched.
  output reg payload_complete_flag, // Payload is in the FIFO.
  output reg packet_done_flag // Last packet bit sent.
);
  localparam T_PRE = 3'h0;
  localparam T_SYNC = 3'h1;
  localparam T_PAY = 3'h2;
  localparam T_CRC = 3'h3;
  localparam T_DONE = 3'h4;
  localparam R_HUNT = 2'h0;
  localparam R_PAY = 2'h1;
  localparam R_CRC = 2'h2;
  localparam R_DONE = 2'h3;

  function [15:0] crc_step;
    input [15:0] c;
    input b;
    input ibm;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (ibm ? `RPH_IBM_POLY : `RPH_CCITT_POLY) : 16'h0000);
    end
  endfunction

  function [8:0] lfsr_step;
    input [8:0] s;
    begin
      lfsr_step = {s[0] ^ s[5], s[8:1]};
    end
  endfunction

  reg rst_m_reg;
  reg rst_s_reg;
  reg bclk_m_reg;
  reg bclk_s_reg;
  reg bclk_d_reg;
  reg rxd_m_reg;
  reg rxd_s_reg;
  reg din_m_reg;
  reg din_s_reg;
  reg [2:0] tx_state_reg;
  reg [7:0] tx_byte_reg;
  reg [2:0] tx_bit_reg;
  reg [15:0] tx_pre_reg;
  reg [4:0] tx_sync_reg;
  reg [10:0] tx_rem_reg;
  reg tx_first_reg;
  reg tx_half_reg;
  reg [8:0] tx_lfsr_reg;
  reg [15:0] tx_crc_reg;
  reg [15:0] tx_crc_sh_reg;
  reg [3:0] tx_ccnt_reg;
  reg [1:0] rx_state_reg;
  reg [31:0] rx_sh_reg;
  reg [7:0] rx_byte_reg;
  reg [2:0] rx_bit_reg;
  reg [10:0] rx_idx_reg;
  reg [10:0] rx_rem_reg;
  reg rx_half_reg;
  reg rx_chip_reg;
  reg [8:0] rx_lfsr_reg;
  reg [15:0] rx_crc_reg;
  reg [15:0] rx_crc_sh_reg;
  reg [3:0] rx_ccnt_reg;
  reg rx_push_reg;
  reg [7:0] rx_data_reg;
  reg rx_flush_reg;
  reg rx_complete_reg;
  reg rx_sample_reg;

  wire rst_n = rst_s_reg;
  wire rise = bclk_s_reg & ~bclk_d_reg;
  wire fall = ~bclk_s_reg & bclk_d_reg;
  wire pk_tx = packet_mode & mode_tx;
  wire pk_rx = packet_mode & mode_rx & ~mode_tx;
  wire unl = ~frame_format_select & (payload_length_setting == 11'h000);
  wire feat_ok = ~(unl & ~sync_detect_enable);
  wire man_tx = (dc_balance_select == `RPH_DCF_MANCH);
  wire wh_tx = (dc_balance_select == `RPH_DCF_WHITE);
  wire man_rx = feat_ok & man_tx;
  wire wh_rx = feat_ok & wh_tx;
  wire addr_en = feat_ok & addr_check_enable;
  wire [15:0] crc_seed = crc_variant_select ? `RPH_IBM_SEED : `RPH_CCITT_SEED;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [5:0] sync_bits = {sync_bytes, 3'h0};
  wire [5:0] sync_shift = 6'h20 - sync_bits;
  wire sync_end = ({1'b0, tx_sync_reg} == sync_bits - 6'h01);
  wire tx_adv = ~man_tx | tx_half_reg;
  wire tx_src = (tx_state_reg == T_CRC) ? tx_crc_sh_reg[15] : tx_byte_reg[7];
  wire tx_dbit = wh_tx ? tx_src ^ tx_lfsr_reg[0] : tx_src;
  wire tx_chip = (man_tx & tx_half_reg) ? ~tx_dbit : tx_dbit;
  wire [15:0] tx_crc_n = crc_step(tx_crc_reg, tx_byte_reg[7], crc_variant_select);
  wire tx_byte_end = tx_adv & (tx_bit_reg == `RPH_BYTE_LAST);
  wire tx_last = unl ? ~fifo_out_valid : (tx_rem_reg == 11'h000);
  wire [16:0] pre_next = {1'b0, tx_pre_reg} + 17'h00001;
  wire start_ok = transmit_start_select ? fifo_out_valid : (fifo_level > {2'h0, fifo_threshold_setting});
  // The byte register rotates, so the whole length byte is still at hand when its last bit goes out.
  wire [7:0] tx_whole = {tx_byte_reg[6:0], tx_byte_reg[7]};
  wire tx_len = frame_format_select & tx_first_reg & (tx_whole != 8'h00);
  wire tx_load = (tx_state_reg == T_SYNC & sync_end) | (tx_state_reg == T_PAY & tx_byte_end & (tx_len | ~tx_last));
  wire tx_pop = pk_tx & rise & tx_load & fifo_out_valid;
  wire rx_adv = ~man_rx | rx_half_reg;
  wire rx_raw = man_rx ? rx_chip_reg : rxd_s_reg;
  wire rx_d = wh_rx ? rx_raw ^ rx_lfsr_reg[0] : rx_raw;
  wire [7:0] rx_b = {rx_byte_reg[6:0], rx_d};
  wire [31:0] sync_mask = 32'hFFFFFFFF >> sync_shift;
  wire sync_hit = ((({rx_sh_reg[30:0], rxd_s_reg}) ^ (sync_word >> sync_shift)) & sync_mask) == 32'h00000000;
  wire [10:0] rx_newrem = (rx_idx_reg == 11'h000) ?
    (frame_format_select ? {3'h0, rx_b} : payload_length_setting - 11'h001) : rx_rem_reg - 11'h001;
  wire addr_pos = frame_format_select ? (rx_idx_reg == 11'h001) : (rx_idx_reg == 11'h000);
  wire [15:0] rx_crc_fin = crc_variant_select ? rx_crc_reg : ~rx_crc_reg;
  wire host_pop = host_rd_ready & fifo_out_valid & ~pk_tx;

  assign host_rd_valid = fifo_out_valid;

  // Receive owns the FIFO write side in packet receive; host writes are ignored then.
  rph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk_sys),
    .rst_n(rst_n),
    .flush(rx_flush_reg),
    .in_valid(pk_rx ? rx_push_reg : host_wr_valid),
    .in_ready(fifo_in_ready),
    .in_data(pk_rx ? rx_data_reg : host_wr_data),
    .out_valid(fifo_out_valid),
    .out_ready(tx_pop | host_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );
  assign host_wr_ready = fifo_in_ready & ~pk_rx;
  assign host_rd_data = fifo_out_data;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_m_reg <= 1'b0;
      rst_s_reg <= 1'b0;
    end
    else
    begin
      rst_m_reg <= 1'b1;
      rst_s_reg <= rst_m_reg;
    end
  end

  // Pin inputs are resynchronised; edges are found from the second and third stages.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bclk_m_reg <= 1'b0;
      bclk_s_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      rxd_m_reg <= 1'b0;
      rxd_s_reg <= 1'b0;
      din_m_reg <= 1'b0;
      din_s_reg <= 1'b0;
    end
    else
    begin
      bclk_m_reg <= bit_clk_in;
      bclk_s_reg <= bclk_m_reg;
      bclk_d_reg <= bclk_s_reg;
      rxd_m_reg <= rx_bit_in;
      rxd_s_reg <= rxd_m_reg;
      din_m_reg <= digital_output_2_in;
      din_s_reg <= din_m_reg;
    end
  end

  // Continuous-mode pins and the bit handed to the modulator.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_bit_out <= 1'b0;
      digital_output_1 <= 1'b0;
      digital_output_2_out <= 1'b0;
      digital_output_2_oe <= 1'b0;
      digital_output_0 <= 1'b0;
      rx_sample_reg <= 1'b0;
    end
    else
    begin
      digital_output_0 <= mode_tx ? packet_done_flag : payload_complete_flag;
      digital_output_1 <= ~packet_mode & (mode_tx | (mode_rx & bit_sync_enable)) & bclk_s_reg;
      digital_output_2_oe <= ~packet_mode & mode_rx & ~mode_tx;
      if (rise)
        rx_sample_reg <= rxd_s_reg;
      if (!bit_sync_enable)
        digital_output_2_out <= rxd_s_reg;
      else if (fall)
        digital_output_2_out <= rx_sample_reg;
      if (pk_tx)
      begin
        if (rise)
          tx_bit_out <= (tx_state_reg == T_PRE) ? ((preamble_bytes == 16'h0000) ? 1'b0 : ~tx_bit_reg[0]) :
            (tx_state_reg == T_SYNC) ? sync_word[~tx_sync_reg] :
            (tx_state_reg == T_DONE) ? 1'b0 : tx_chip;
      end
      else if (~packet_mode & mode_tx)
      begin
        if (rise)
          tx_bit_out <= din_s_reg;
      end
      else
        tx_bit_out <= 1'b0;
    end
  end

  // Transmit framer, advanced on each rising edge of the modem bit clock.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= T_PRE;
      tx_byte_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_pre_reg <= 16'h0000;
      tx_sync_reg <= 5'h00;
      tx_rem_reg <= 11'h000;
      tx_first_reg <= 1'b0;
      tx_half_reg <= 1'b0;
      tx_lfsr_reg <= `RPH_WHITE_SEED;
      tx_crc_reg <= `RPH_CCITT_SEED;
      tx_crc_sh_reg <= 16'h0000;
      tx_ccnt_reg <= 4'h0;
      packet_done_flag <= 1'b0;
    end
    else if (!pk_tx)
    begin
      tx_state_reg <= T_PRE;
      tx_bit_reg <= 3'h0;
      tx_pre_reg <= 16'h0000;
      tx_half_reg <= 1'b0;
      tx_lfsr_reg <= `RPH_WHITE_SEED;
      tx_crc_reg <= crc_seed;
      if (!mode_tx)
        packet_done_flag <= 1'b0;
    end
    else if (rise)
    begin
      case (tx_state_reg)
        T_PRE:
        begin
          tx_bit_reg <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == `RPH_BYTE_LAST)
          begin
            if (pre_next[16] == 1'b0)
              tx_pre_reg <= pre_next[15:0];
            // A start condition already met on entry starts the packet after the preamble.
            if (start_ok & (pre_next >= {1'b0, preamble_bytes}))
            begin
              tx_state_reg <= T_SYNC;
              tx_sync_reg <= 5'h00;
            end
          end
        end
        T_SYNC:
        begin
          tx_sync_reg <= tx_sync_reg + 5'h01;
          if (sync_end)
          begin
            tx_state_reg <= T_PAY;
            tx_bit_reg <= 3'h0;
            tx_first_reg <= 1'b1;
            tx_byte_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
            tx_rem_reg <= payload_length_setting - 11'h001;
          end
        end
        T_PAY:
        begin
          if (man_tx)
            tx_half_reg <= ~tx_half_reg;
          if (tx_adv)
          begin
            tx_crc_reg <= tx_crc_n;
            tx_lfsr_reg <= lfsr_step(tx_lfsr_reg);
            tx_bit_reg <= tx_bit_reg + 3'h1;
            tx_byte_reg <= {tx_byte_reg[6:0], tx_byte_reg[7]};
          end
          if (tx_byte_end)
          begin
            tx_first_reg <= 1'b0;
            if (tx_len)
            begin
              tx_rem_reg <= {3'h0, tx_whole} - 11'h001;
              tx_byte_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
            end
            else if (!tx_last)
            begin
              tx_rem_reg <= tx_rem_reg - 11'h001;
              tx_byte_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
            end
            else if (crc_enable_bit)
            begin
              tx_state_reg <= T_CRC;
              tx_ccnt_reg <= 4'h0;
              tx_crc_sh_reg <= crc_variant_select ? tx_crc_n : ~tx_crc_n;
            end
            else
              tx_state_reg <= T_DONE;
          end
        end
        T_CRC:
        begin
          if (man_tx)
            tx_half_reg <= ~tx_half_reg;
          if (tx_adv)
          begin
            tx_lfsr_reg <= lfsr_step(tx_lfsr_reg);
            tx_crc_sh_reg <= {tx_crc_sh_reg[14:0], 1'b0};
            tx_ccnt_reg <= tx_ccnt_reg + 4'h1;
            if (tx_ccnt_reg == `RPH_CRC_BITS)
              tx_state_reg <= T_DONE;
          end
        end
        T_DONE:
          packet_done_flag <= 1'b1;
        default:
          tx_state_reg <= T_PRE;
      endcase
    end
  end

  // Receive deframer; bits are sampled on rising bit clock edges in packet mode.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= R_HUNT;
      rx_sh_reg <= 32'h00000000;
      rx_byte_reg <= 8'h00;
      rx_bit_reg <= 3'h0;
      rx_idx_reg <= 11'h000;
      rx_rem_reg <= 11'h000;
      rx_half_reg <= 1'b0;
      rx_chip_reg <= 1'b0;
      rx_lfsr_reg <= `RPH_WHITE_SEED;
      rx_crc_reg <= `RPH_CCITT_SEED;
      rx_crc_sh_reg <= 16'h0000;
      rx_ccnt_reg <= 4'h0;
      rx_push_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_flush_reg <= 1'b0;
      rx_complete_reg <= 1'b0;
      crc_good_flag <= 1'b0;
    end
    else
    begin
      rx_push_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
      rx_complete_reg <= 1'b0;
      if (!pk_rx)
        rx_state_reg <= R_HUNT;
      else if (rise)
      begin
        case (rx_state_reg)
          R_HUNT:
          begin
            rx_sh_reg <= {rx_sh_reg[30:0], rxd_s_reg};
            if (sync_detect_enable ? sync_hit : (unl & fifo_fill_select))
            begin
              rx_state_reg <= R_PAY;
              rx_bit_reg <= 3'h0;
              rx_idx_reg <= 11'h000;
              rx_half_reg <= 1'b0;
              rx_lfsr_reg <= `RPH_WHITE_SEED;
              rx_crc_reg <= crc_seed;
              crc_good_flag <= 1'b0;
            end
          end
          R_PAY:
          begin
            if (man_rx)
              rx_half_reg <= ~rx_half_reg;
            if (man_rx & ~rx_half_reg)
              rx_chip_reg <= rxd_s_reg;
            if (rx_adv)
            begin
              rx_crc_reg <= crc_step(rx_crc_reg, rx_d, crc_variant_select);
              rx_lfsr_reg <= lfsr_step(rx_lfsr_reg);
              rx_byte_reg <= rx_b;
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == `RPH_BYTE_LAST)
              begin
                if (rx_idx_reg != `RPH_FIXED_LEN_MAX)
                  rx_idx_reg <= rx_idx_reg + 11'h001;
                if (frame_format_select & (rx_idx_reg == 11'h000) & ({3'h0, rx_b} > payload_length_setting))
                begin
                  rx_flush_reg <= 1'b1;
                  rx_state_reg <= R_HUNT;
                end
                else if (addr_en & ~unl & addr_pos & (rx_b != local_node_id))
                begin
                  rx_flush_reg <= 1'b1;
                  rx_state_reg <= R_HUNT;
                end
                else
                begin
                  rx_push_reg <= 1'b1;
                  rx_data_reg <= rx_b;
                  rx_rem_reg <= rx_newrem;
                  if (~unl & (rx_newrem == 11'h000))
                  begin
                    rx_ccnt_reg <= 4'h0;
                    if (crc_enable_bit)
                      rx_state_reg <= R_CRC;
                    else
                    begin
                      rx_state_reg <= R_DONE;
                      rx_complete_reg <= 1'b1;
                    end
                  end
                end
              end
            end
          end
          R_CRC:
          begin
            if (man_rx)
              rx_half_reg <= ~rx_half_reg;
            if (man_rx & ~rx_half_reg)
              rx_chip_reg <= rxd_s_reg;
            if (rx_adv)
            begin
              rx_lfsr_reg <= lfsr_step(rx_lfsr_reg);
              rx_crc_sh_reg <= {rx_crc_sh_reg[14:0], rx_d};
              rx_ccnt_reg <= rx_ccnt_reg + 4'h1;
              if (rx_ccnt_reg == `RPH_CRC_BITS)
              begin
                rx_state_reg <= R_DONE;
                crc_good_flag <= ({rx_crc_sh_reg[14:0], rx_d} == rx_crc_fin);
                if (({rx_crc_sh_reg[14:0], rx_d} == rx_crc_fin) | crc_fail_keep_bit)
                  rx_complete_reg <= 1'b1;
                else
                  rx_flush_reg <= 1'b1;
              end
            end
          end
          R_DONE:
            rx_state_reg <= R_DONE;
          default:
            rx_state_reg <= R_HUNT;
        endcase
      end
    end
  end

  // Completion stays up until the host drains the FIFO or a receive flush clears it; a new completion wins over the clear.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      payload_complete_flag <= 1'b0;
    else if (rx_complete_reg)
      payload_complete_flag <= 1'b1;
    else if (rx_flush_reg | (host_pop & (fifo_level == 8'h01)))
      payload_complete_flag <= 1'b0;
  end
endmodule

//--- bench/rph_chk_sva.sv
// Assertion checker bound to the radio packet handler top module.
`timescale 1ns/10ps
module rph_chk #(parameter FIFO_DEPTH = 8) (
  input wire clk_sys, rstn, packet_mode, mode_tx, mode_rx, bit_sync_enable, // Clock, reset, modes.
  input wire host_wr_valid, host_wr_ready, host_rd_ready, tx_bit_out, // Host FIFO side and modulator bit.
  input wire digital_output_0, digital_output_1, digital_output_2_oe, packet_done_flag, // Pins and flag.
  input wire [7:0] fifo_level // FIFO fill level.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  lvl_cap_a: assert property (fifo_level <= FIFO_DEPTH) else $error("fifo level above depth");
  wr_count_a: assert property (host_wr_valid && host_wr_ready && !host_rd_ready && !mode_rx && !mode_tx
    |=> fifo_level == $past(fifo_level) + 8'h01) else $error("write did not raise level");
  full_ref_a: assert property (fifo_level == FIFO_DEPTH |-> !host_wr_ready) else $error("full fifo ready");
  rx_ref_a: assert property (packet_mode && mode_rx && !mode_tx |-> !host_wr_ready) else $error("rx write open");
  raw_noclk_a: assert property ((!packet_mode && mode_rx && !mode_tx && !bit_sync_enable)[*2]
    |-> !digital_output_1 && digital_output_2_oe) else $error("raw rx pins wrong");
  tx_oe_a: assert property ((!packet_mode && mode_tx)[*2] |-> !digital_output_2_oe) else $error("tx drives data");
  done_pin_a: assert property (mode_tx[*2] |-> digital_output_0 == $past(packet_done_flag))
    else $error("output 0 does not follow done");
  done_line_a: assert property ($rose(packet_done_flag) |-> ##[0:2] !tx_bit_out) else $error("line not low");
endmodule
bind rph_packet_handler rph_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.*);

//--- bench/rph_modem_model.sv
// Modem side model: bit clock in frames, sends a frame, watches the transmit bit.
`timescale 1ns/10ps
module rph_modem_model #(parameter logic [31:0] PAT = 32'hAAD35AC1) (
  input wire logic run, // Frame in progress.
  input wire logic tx_bit, // Bit from the framer.
  output logic bit_clk = 1'h0, // Bit clock, still outside frames.
  output logic rx_bit = 1'h0, // Bit toward the deframer.
  output logic seen = 1'h0 // Frame pattern was seen on tx_bit.
);
  logic [31:0] cap = 32'h0, pat = PAT;
  initial forever
  begin
    #80;
    bit_clk = run & ~bit_clk;
  end
  always @(posedge bit_clk)
  begin
    cap = {cap[30:0], tx_bit};
    seen = seen | (cap == PAT);
  end
  // After the frame the pattern repeats inverted, so a stale level cannot pass for data.
  always @(negedge bit_clk)
  begin
    rx_bit = pat[31];
    pat = {pat[30:0], ~pat[31]};
  end
  // A finished run restarts the pattern and forgets the last match, so each test sees its own frame.
  always @(negedge run)
  begin
    pat = PAT;
    seen = 1'h0;
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the radio packet handler.
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'h0, rstn = 1'h0, packet_mode = 1'h0, mode_tx = 1'h0, mode_rx = 1'h0, bit_sync_enable = 1'h0;
  logic frame_format_select = 1'h0, transmit_start_select = 1'h1, sync_detect_enable = 1'h1, run = 1'h0;
  logic crc_enable_bit = 1'h0, crc_fail_keep_bit = 1'h0, crc_variant_select = 1'h0, addr_check_enable = 1'h0;
  logic host_wr_valid = 1'h0, host_rd_ready = 1'h0, fifo_fill_select = 1'h0;
  logic [10:0] payload_length_setting = 11'h002;
  logic [5:0] fifo_threshold_setting = 6'h00;
  logic [15:0] preamble_bytes = 16'h0001;
  logic [2:0] sync_bytes = 3'h1;
  logic [31:0] sync_word = 32'hD3000000;
  logic [1:0] dc_balance_select = 2'h0;
  logic [7:0] local_node_id = 8'h00, host_wr_data = 8'h00;
  wire host_wr_ready, host_rd_valid, bit_clk_in, rx_bit_in, tx_bit_out, digital_output_0, digital_output_1, seen;
  wire digital_output_2_in, digital_output_2_out, digital_output_2_oe, crc_good_flag, payload_complete_flag;
  wire packet_done_flag;
  wire [7:0] host_rd_data, fifo_level;
  int error_cnt = 0, checked = 0;
  localparam logic [31:0] PAT = 32'hAAD35AC1;
  logic pin_dat = 1'h0, hit = 1'h0;
  logic [31:0] cap = 32'h0;
  assign digital_output_2_in = digital_output_2_oe ? digital_output_2_out : pin_dat;
  rph_packet_handler dut_u (.*);
  rph_modem_model #(.PAT(PAT)) model_u (.run(run), .tx_bit(tx_bit_out), .bit_clk(bit_clk_in), .rx_bit(rx_bit_in),
    .seen(seen));
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    while (host_wr_ready !== 1'h1) @(posedge clk_sys);
    #1 host_wr_valid = 1'h1;
    host_wr_data = b;
    @(posedge clk_sys);
    #1 host_wr_valid = 1'h0;
  endtask
  task automatic rd(input logic [7:0] e);
    #1 host_rd_ready = 1'h1;
    chk(host_rd_data, e);
    @(posedge clk_sys);
    #1 host_rd_ready = 1'h0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'h1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) wr(8'h30 + i[7:0]);
    chk(fifo_level, 8'h08);
    chk({7'h0, host_wr_ready}, 8'h00);
    for (int i = 0; i < 8; i++) rd(8'h30 + i[7:0]);
    chk({7'h0, host_rd_valid}, 8'h00);
    $display("fifo test done");
    // Bit sync goes first, while the model's frame pattern is still at its start.
    #1 mode_rx = 1'h1;
    bit_sync_enable = 1'h1;
    run = 1'h1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge digital_output_1);
      cap = {cap[30:0], digital_output_2_out};
      hit = hit | (cap == PAT);
    end
    chk({7'h0, hit}, 8'h01);
    #1 bit_sync_enable = 1'h0;
    repeat (10) @(posedge clk_sys);
    chk({6'h0, digital_output_1, digital_output_2_oe}, 8'h01);
    #1 mode_tx = 1'h1;
    repeat (10) @(posedge clk_sys);
    chk({7'h0, digital_output_2_oe}, 8'h00);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge digital_output_1);
      #1 pin_dat = PAT[i];
    end
    repeat (2) @(negedge digital_output_1);
    chk({7'h0, seen}, 8'h01);
    #1 mode_tx = 1'h0;
    mode_rx = 1'h0;
    run = 1'h0;
    packet_mode = 1'h1;
    $display("continuous test done");
    wr(8'h5A);
    wr(8'hC1);
    #1 mode_tx = 1'h1;
    run = 1'h1;
    for (int i = 0; i < 3000 && packet_done_flag !== 1'h1; i++) @(posedge clk_sys);
    @(posedge clk_sys);
    chk({6'h0, seen, digital_output_0}, 8'h03);
    #1 mode_tx = 1'h0;
    run = 1'h0;
    $display("packet transmit test done");
    repeat (20) @(posedge clk_sys);
    #1 mode_rx = 1'h1;
    run = 1'h1;
    for (int i = 0; i < 3000 && payload_complete_flag !== 1'h1; i++) @(posedge clk_sys);
    @(posedge clk_sys);
    #1 run = 1'h0;
    mode_rx = 1'h0;
    chk({6'h0, payload_complete_flag, digital_output_0}, 8'h03);
    rd(8'h5A);
    rd(8'hC1);
    chk({7'h0, payload_complete_flag}, 8'h00);
    $display("packet receive test done");
    end_sim;
  end
endmodule
